/* File: logic/crx_stream_port.sv */
// Receive stream port: registered data and sideband, credit count, activation handshake.
// Assumes the packet source and user logic run on mclk; no pin synchronisers needed.
`default_nettype none
`include "crx_defs.svh"

module crx_stream_port
    import crx_pkg::*;
(
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    // Core-side packet source
    input wire logic linkEnable,
    input wire logic srcValid,
    input wire logic [`CRX_DATA_W-1:0] srcData,
    input wire crx_side_s srcSide,
    output logic srcReady,
    output logic srcFlagError,
    // User stream
    output logic [`CRX_DATA_W-1:0] rxData,
    output crx_side_s rxSide,
    output logic rxValid,
    // Credits and link handshake
    input wire logic creditGnt,
    output logic creditRtn,
    output logic activeReq,
    input wire logic activeAck,
    input wire logic deactHint
);

    // ----------------------------------------
    // Start flag decode
    // ----------------------------------------
    function automatic logic [2:0] start_count(input logic [3:0] flags);
        case (flags)
            `CRX_SF_NONE: start_count = 3'h0;
            `CRX_SF_ONE: start_count = 3'h1;
            `CRX_SF_TWO: start_count = 3'h2;
            `CRX_SF_THREE: start_count = 3'h3;
            `CRX_SF_FOUR: start_count = 3'h4;
            default: start_count = 3'h0;
        endcase
    endfunction

    function automatic logic flags_legal(input logic [3:0] flags);
        flags_legal = (flags == `CRX_SF_NONE) || (flags == `CRX_SF_ONE) || (flags == `CRX_SF_TWO) ||
                      (flags == `CRX_SF_THREE) || (flags == `CRX_SF_FOUR);
    endfunction

    logic [2:0] starts;
    logic legal;
    logic enough;
    logic fire;
    crx_side_s cleanSide;

    always_comb begin
        starts = start_count(srcSide.startFlags);
        legal = flags_legal(srcSide.startFlags);
        cleanSide = srcSide;
        // reserved flags blocked
        // A beat with a reserved code is dropped rather than passed with a guess
        if (!legal) begin
            cleanSide.startFlags = `CRX_SF_NONE;
        end
    end

    // ----------------------------------------
    // Link state
    // ----------------------------------------
    crx_link_e linkState_ff, nxt_linkState;
    logic creditRtn_ff, nxt_creditRtn;

    always_comb begin
        nxt_linkState = linkState_ff;
        nxt_creditRtn = 1'b0;
        case (linkState_ff)
            LINK_STOP: begin
                if (linkEnable && !deactHint) begin
                    nxt_linkState = LINK_REQ;
                end
            end
            LINK_REQ: begin
                if (deactHint || !linkEnable) begin
                    nxt_linkState = LINK_RETURN;
                    nxt_creditRtn = 1'b1;
                end else if (activeAck) begin
                    nxt_linkState = LINK_ACTIVE;
                end
            end
            LINK_ACTIVE: begin
                if (deactHint || !linkEnable) begin
                    nxt_linkState = LINK_RETURN;
                    nxt_creditRtn = 1'b1;
                end
            end
            LINK_RETURN: nxt_linkState = LINK_STOP;
            default: nxt_linkState = LINK_STOP;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            linkState_ff <= LINK_STOP;
            creditRtn_ff <= 1'b0;
        end else if (clkEn) begin
            linkState_ff <= nxt_linkState;
            creditRtn_ff <= nxt_creditRtn;
        end
    end

    assign activeReq = (linkState_ff == LINK_REQ) || (linkState_ff == LINK_ACTIVE);
    assign creditRtn = creditRtn_ff;

    // ----------------------------------------
    // Credits
    // ----------------------------------------
    logic [`CRX_CREDIT_W-1:0] creditCnt_ff, nxt_creditCnt;
    logic grantTaken;

    // send only with credits
    // Continuation beats start nothing and need no credit; valid may gap
    assign enough = creditCnt_ff >= `CRX_CREDIT_W'(starts);
    assign srcReady = clkEn && (linkState_ff == LINK_ACTIVE) && enough && !deactHint && linkEnable;
    assign fire = srcValid && srcReady && legal;
    assign srcFlagError = srcValid && srcReady && !legal;
    assign grantTaken = creditGnt && activeReq && (creditCnt_ff != `CRX_CREDIT_MAX);

    always_comb begin
        nxt_creditCnt = creditCnt_ff;
        // grant adds, start spends
        // Grant and spend in one cycle both count; a grant is lost at CRX_CREDIT_MAX, while activeReq or clkEn is low, or in the cycle that returns credits
        if (fire) begin
            nxt_creditCnt = nxt_creditCnt - `CRX_CREDIT_W'(starts);
        end
        if (grantTaken) begin
            nxt_creditCnt = nxt_creditCnt + `CRX_CREDIT_W'(1);
        end
        if (nxt_creditRtn) begin
            nxt_creditCnt = '0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            creditCnt_ff <= '0;
        end else if (clkEn) begin
            creditCnt_ff <= nxt_creditCnt;
        end
    end

    // ----------------------------------------
    // Output beat
    // ----------------------------------------
    logic [`CRX_DATA_W-1:0] rxData_ff, nxt_rxData;
    crx_side_s rxSide_ff, nxt_rxSide;
    logic rxValid_ff, nxt_rxValid;

    always_comb begin
        nxt_rxData = rxData_ff;
        nxt_rxSide = rxSide_ff;
        nxt_rxValid = fire;
        if (fire) begin
            nxt_rxData = srcData;
            nxt_rxSide = cleanSide;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxData_ff <= '0;
            rxSide_ff <= '0;
            rxValid_ff <= 1'b0;
        end else if (clkEn) begin
            rxData_ff <= nxt_rxData;
            rxSide_ff <= nxt_rxSide;
            rxValid_ff <= nxt_rxValid;
        end
    end

    assign rxData = rxData_ff;
    assign rxSide = rxSide_ff;
    assign rxValid = rxValid_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_beat_follows_fire: assert property (clkEn && fire |=> rxValid && rxData == $past(srcData))
        else $error("beat not presented after accept");
    a_valid_needs_active: assert property (rxValid |-> $past(linkState_ff) == LINK_ACTIVE)
        else $error("valid outside active state");
    a_credit_cover: assert property (fire |-> creditCnt_ff >= `CRX_CREDIT_W'(starts))
        else $error("beat sent without credits");
    a_flags_legal: assert property (rxValid |-> flags_legal(rxSide.startFlags))
        else $error("reserved start flags driven");
    a_hint_returns: assert property (clkEn && linkState_ff == LINK_ACTIVE && deactHint
        |=> creditRtn && !rxValid ##1 creditCnt_ff == '0 || !clkEn)
        else $error("hint did not return credits");
    a_return_clears: assert property (creditRtn && clkEn |=> creditCnt_ff == '0 && !activeReq)
        else $error("credits kept after return");
    a_ack_activates: assert property (clkEn && linkState_ff == LINK_REQ && activeAck && !deactHint && linkEnable
        |=> linkState_ff == LINK_ACTIVE && activeReq)
        else $error("acknowledge did not activate");
    a_grant_counts: assert property (clkEn && grantTaken && !fire && !nxt_creditRtn
        |=> creditCnt_ff == $past(creditCnt_ff) + `CRX_CREDIT_W'(1))
        else $error("grant not counted");
    a_spend_counts: assert property (clkEn && fire && !grantTaken && !nxt_creditRtn
        |=> creditCnt_ff == $past(creditCnt_ff) - `CRX_CREDIT_W'($past(starts)))
        else $error("starts not charged");

    c_four_starts: cover property (fire && srcSide.startFlags == `CRX_SF_FOUR);
    c_activation: cover property (linkState_ff == LINK_REQ ##1 linkState_ff == LINK_ACTIVE);
    c_credit_gap: cover property (srcValid && linkState_ff == LINK_ACTIVE && !enough);
    c_credit_return: cover property (creditRtn && $past(creditCnt_ff) != '0);

endmodule

`default_nettype wire

/* File: logic/crx_defs.svh */
// Constants of the receive stream credit port: widths, start flag codes, credit limits.
// Assumes inclusion by the package, the port module and the bench, once each.
//
// Function
// - Received packet data goes out on a 512-bit data bus.
// - A 100-bit sideband describes the beat and means something only while valid is high.
// - Valid is high in every cycle in which the data bus carries a beat.
// - With no credits left valid may drop between packets.
// - On going to the deactivated state the port returns its credits with a pulse.
// - The deactivation hint makes the port return credits and deactivate.
// - Start flags sit in sideband bits 3:0; 0000 is no start, 0001 one start at the first pointer.
// - Start flags 0011 mean two starts at the first and second pointers.
// - Start flags 0111 mean three starts at the first three pointers.
// - Start flags 1111 mean four starts using all four pointers.
// - No reserved start flag value is ever driven out.
// - The first start pointer in bits 5:4 selects byte 0, 16, 32 or 48.
`ifndef CRX_DEFS_SVH
`define CRX_DEFS_SVH

`define CRX_DATA_W 512
`define CRX_SIDE_W 100
`define CRX_UPPER_W 88
`define CRX_CREDIT_W 8
`define CRX_CREDIT_MAX 8'hff
`define CRX_SF_NONE 4'h0
`define CRX_SF_ONE 4'h1
`define CRX_SF_TWO 4'h3
`define CRX_SF_THREE 4'h7
`define CRX_SF_FOUR 4'hf
`define CRX_PTR_BYTE0 2'h0
`define CRX_PTR_BYTE16 2'h1
`define CRX_PTR_BYTE32 2'h2
`define CRX_PTR_BYTE48 2'h3

`endif

/* File: logic/crx_pkg.sv */
// Types shared by the receive stream credit port.
// Assumes crx_defs.svh is on the include path.
`default_nettype none
`include "crx_defs.svh"

package crx_pkg;

    // Sideband layout, start flags in the low bits
    typedef struct packed {
        logic [`CRX_UPPER_W-1:0] upper;
        logic [1:0] startPointerFourth;
        logic [1:0] startPointerThird;
        logic [1:0] startPointerSecond;
        logic [1:0] startPointerFirst;
        logic [3:0] startFlags;
    } crx_side_s;

    typedef enum logic [1:0] {
        LINK_STOP,
        LINK_REQ,
        LINK_ACTIVE,
        LINK_RETURN
    } crx_link_e;

endpackage

`default_nettype wire

/* File: verif/crx_user_model.sv */
// User-side model: acknowledges activation, then grants credits.
// Assumes it shares mclk and rstn with the port; bench steers pacing.
`default_nettype none
module crx_user_model
    import crx_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Bench controls
    input wire logic slowAck,
    input wire logic [7:0] initCredits,
    input wire logic extraGnt,
    // Port handshake
    input wire logic activeReq,
    output logic activeAck,
    output logic creditGnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    logic [7:0] owed;
    // ack when ready, all credits first
    always @(posedge mclk or negedge rstn) begin
        if (!rstn || !activeReq) begin
            waitCnt <= 4'h0;
            activeAck <= 1'b0;
            owed <= initCredits;
            creditGnt <= 1'b0;
        end else begin
            waitCnt <= waitCnt + 4'h1;
            activeAck <= activeAck || (waitCnt >= (slowAck ? 4'h6 : 4'h1));
            creditGnt <= activeAck && (owed != 8'h0 || extraGnt);
            if (activeAck && owed != 8'h0) begin
                owed <= owed - 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/test_crx_stream_port.sv */
// Bench for the receive stream port: flags, credits, link handshake.
// Assumes the user model on the far side and one 100 MHz clock.
`default_nettype none
`include "crx_defs.svh"
module test_crx_stream_port
    import crx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rstn, clkEn, linkEnable, srcValid, creditGnt, activeAck, deactHint, extraGnt, slowAck;
    logic srcReady, srcFlagError, rxValid, creditRtn, activeReq;
    logic [`CRX_DATA_W-1:0] srcData, rxData;
    crx_side_s srcSide, rxSide;
    int miscompares = 0;
    int samplesChecked = 0;

    crx_stream_port dut (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .linkEnable(linkEnable),
        .srcValid(srcValid), .srcData(srcData), .srcSide(srcSide), .srcReady(srcReady),
        .srcFlagError(srcFlagError), .rxData(rxData), .rxSide(rxSide), .rxValid(rxValid),
        .creditGnt(creditGnt), .creditRtn(creditRtn), .activeReq(activeReq),
        .activeAck(activeAck), .deactHint(deactHint));
    crx_user_model user (.mclk(mclk), .rstn(rstn), .slowAck(slowAck), .initCredits(8'ha),
        .extraGnt(extraGnt), .activeReq(activeReq), .activeAck(activeAck), .creditGnt(creditGnt));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [511:0] got, input logic [511:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bounded wait; a hang ends the run
    task automatic waitReady();
        int n;
        n = 0;
        @(negedge mclk);
        while (srcReady !== 1'b1) begin
            n++;
            if (n > 40) begin
                miscompares++;
                tally_and_finish();
            end
            @(negedge mclk);
        end
    endtask

    task automatic sendBeat(input logic [3:0] flags, input logic [1:0] ptr, input logic expOut);
        crx_side_s side;
        logic [511:0] dat;
        side = {{11{8'ha5}}, 2'h3, 2'h2, 2'h1, ptr, flags};
        dat = {64{ptr, 2'h1, flags}};
        @(posedge mclk);
        srcValid <= 1'b1;
        srcData <= dat;
        srcSide <= side;
        waitReady();
        chk(srcFlagError, !expOut);
        @(posedge mclk);
        srcValid <= 1'b0;
        @(negedge mclk);
        chk(rxValid, expOut);
        if (expOut) begin
            chk(rxData, dat);
            chk(rxSide, side);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_activate();
        @(negedge mclk);
        chk(activeReq, 1'b0);
        @(posedge mclk);
        linkEnable <= 1'b1;
        @(negedge mclk);
        chk(activeReq, 1'b0);
        @(negedge mclk);
        chk(activeReq, 1'b1);
        waitReady();
        chk(activeAck, 1'b1);
        $display("activation done");
    endtask

    // Ten credits: 0+1+2+3+4 starts, pointer walks all four codes
    task automatic t_flags();
        sendBeat(4'h0, 2'h0, 1'b1);
        sendBeat(4'h1, 2'h1, 1'b1);
        sendBeat(4'h3, 2'h2, 1'b1);
        sendBeat(4'h7, 2'h3, 1'b1);
        sendBeat(4'hf, 2'h0, 1'b1);
        $display("start flags done");
    endtask

    task automatic t_no_credit();
        @(posedge mclk);
        srcSide.startFlags <= 4'h1;
        srcValid <= 1'b1;
        repeat (3) begin
            @(negedge mclk);
            chk(srcReady, 1'b0);
            chk(rxValid, 1'b0);
        end
        @(posedge mclk);
        extraGnt <= 1'b1;
        @(posedge mclk);
        extraGnt <= 1'b0;
        waitReady();
        @(posedge mclk);
        srcValid <= 1'b0;
        @(negedge mclk);
        chk(rxValid, 1'b1);
        @(posedge mclk);
        extraGnt <= 1'b1;
        repeat (4) @(posedge mclk);
        extraGnt <= 1'b0;
        sendBeat(4'h2, 2'h0, 1'b0);
        $display("credit stall done");
    endtask

    task automatic t_deact();
        @(posedge mclk);
        deactHint <= 1'b1;
        @(negedge mclk);
        chk(srcReady, 1'b0);
        @(negedge mclk);
        chk(creditRtn, 1'b1);
        chk(activeReq, 1'b0);
        @(negedge mclk);
        chk(creditRtn, 1'b0);
        @(posedge mclk);
        deactHint <= 1'b0;
        slowAck <= 1'b0;
        waitReady();
        chk(activeReq, 1'b1);
        sendBeat(4'h1, 2'h3, 1'b1);
        $display("deactivation done");
    endtask

    // Freeze holds a pending beat; link drop and hint in request state both return credits
    task automatic t_freeze_drop();
        repeat (12) @(posedge mclk);
        clkEn <= 1'b0;
        srcSide.startFlags <= 4'h1;
        srcValid <= 1'b1;
        repeat (3) begin
            @(negedge mclk);
            chk(srcReady, 1'b0);
            chk(rxValid, 1'b0);
        end
        @(posedge mclk);
        clkEn <= 1'b1;
        waitReady();
        @(posedge mclk);
        srcValid <= 1'b0;
        @(negedge mclk);
        chk(rxValid, 1'b1);
        chk(rxSide.startFlags, 4'h1);
        @(posedge mclk);
        linkEnable <= 1'b0;
        @(negedge mclk);
        chk(srcReady, 1'b0);
        @(negedge mclk);
        chk(creditRtn, 1'b1);
        chk(activeReq, 1'b0);
        @(posedge mclk);
        slowAck <= 1'b1;
        linkEnable <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(activeReq, 1'b1);
        @(posedge mclk);
        deactHint <= 1'b1;
        repeat (2) @(negedge mclk);
        chk(creditRtn, 1'b1);
        chk(activeAck, 1'b0);
        $display("freeze and link drop done");
    endtask

    // ----------------------------------------
    // Clock and main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rstn = 1'b0;
        clkEn = 1'b1;
        linkEnable = 1'b0;
        srcValid = 1'b0;
        srcData = '0;
        srcSide = '0;
        deactHint = 1'b0;
        extraGnt = 1'b0;
        slowAck = 1'b1;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        t_activate();
        t_flags();
        t_no_credit();
        t_deact();
        t_freeze_drop();
        tally_and_finish();
    end
endmodule
`default_nettype wire
